// file: rtl/sfq_pkg.sv
// package: opcodes, status bits, timing and carrier types for the flash command sequencer
package sfq_pkg;

	// flash opcodes
	localparam logic [7:0] OP_FAST_READ    = 8'h0b;
	localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_CHIP_ERASE   = 8'hc7;
	localparam logic [7:0] OP_STATUS_READ  = 8'h05;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;

	// status byte layout and the value that drops every protection bit
	localparam int         WIP_BIT          = 0;
	localparam int         WEL_BIT          = 1;
	localparam logic [7:0] STATUS_UNPROTECT = 8'h00;

	// serial clock: fixed divider, half period in core cycles
	localparam int         CORE_CLK_MHZ     = 100;
	localparam int         SCLK_TARGET_MHZ  = 25;
	localparam int         SCLK_HALF_CYC    = CORE_CLK_MHZ / (2 * SCLK_TARGET_MHZ);
	localparam logic [3:0] SCLK_HALF_LAST   = 4'(SCLK_HALF_CYC - 1);

	// chip select high time between commands
	localparam int         CS_HIGH_NS       = 200;
	localparam int         CLK_PERIOD_NS    = 10;
	localparam int         CS_HIGH_CYC      = (CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] CS_HIGH_LAST     = 8'(CS_HIGH_CYC - 1);

	// user operations
	typedef enum logic [2:0]
	{
		SFQ_OP_READ    = 3'h0,
		SFQ_OP_PROGRAM = 3'h1,
		SFQ_OP_SECTOR  = 3'h2,
		SFQ_OP_CHIP    = 3'h3
	} sfq_op_type;

	typedef struct packed
	{
		sfq_op_type  op;
		logic [23:0] addr;
	} sfq_req_type;

	// a single byte frame for the shifter
	typedef struct packed
	{
		logic [7:0] data;
		logic       last;
	} sfq_byte_type;

endpackage : sfq_pkg

// file: rtl/sfq_shifter.sv
// mode 0 byte shifter: drives the serial clock and moves one byte each way
module sfq_shifter
(
	// clock and reset
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_n_i,
	// byte request
	input  wire logic                  start_i,
	input  wire sfq_pkg::sfq_byte_type tx_i,
	output logic                       done_o,
	output logic [7:0]                 rx_o,
	// serial lines
	input  wire logic                  miso_i,
	output logic                       sclk_o,
	output logic                       mosi_o
);

	logic [3:0] div_r;
	logic [3:0] div_nxt;
	logic [2:0] bit_r;
	logic [2:0] bit_nxt;
	logic       busy_r;
	logic       busy_nxt;
	logic       sclk_r;
	logic       sclk_nxt;
	logic [7:0] sh_r;
	logic [7:0] sh_nxt;
	logic [7:0] rx_r;
	logic [7:0] rx_nxt;
	logic       done_r;
	logic       done_nxt;

	always_comb
	begin
		div_nxt  = div_r;
		bit_nxt  = bit_r;
		busy_nxt = busy_r;
		sclk_nxt = sclk_r;
		sh_nxt   = sh_r;
		rx_nxt   = rx_r;
		done_nxt = 1'b0;
		if (!busy_r)
		begin
			if (start_i)
			begin
				busy_nxt = 1'b1;
				sh_nxt   = tx_i.data;
				bit_nxt  = 3'h7;
				div_nxt  = sfq_pkg::SCLK_HALF_LAST;
				sclk_nxt = 1'b0;
			end
		end
		else if (div_r != 4'h0)
			div_nxt = div_r - 4'h1;
		else
		begin
			div_nxt = sfq_pkg::SCLK_HALF_LAST;
			if (!sclk_r)
			begin
				sclk_nxt = 1'b1;
			end
			else
			begin
				// falling edge: advance output; clock comes back low at byte end
				// the bit for the pin's rising edge only clears the pin stage and
				// the input synchroniser now, so it is taken here, not at the rise
				sclk_nxt = 1'b0;
				rx_nxt   = {rx_r[6:0], miso_i};
				sh_nxt   = {sh_r[6:0], 1'b0};
				if (bit_r == 3'h0)
				begin
					busy_nxt = 1'b0;
					done_nxt = 1'b1;
				end
				else
					bit_nxt = bit_r - 3'h1;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			div_r  <= 4'h0;
			bit_r  <= 3'h0;
			busy_r <= 1'b0;
			sclk_r <= 1'b0;
			sh_r   <= 8'h00;
			rx_r   <= 8'h00;
			done_r <= 1'b0;
		end
		else
		begin
			div_r  <= div_nxt;
			bit_r  <= bit_nxt;
			busy_r <= busy_nxt;
			sclk_r <= sclk_nxt;
			sh_r   <= sh_nxt;
			rx_r   <= rx_nxt;
			done_r <= done_nxt;
		end
	end

	assign sclk_o = sclk_r;
	assign mosi_o = sh_r[7];
	assign done_o = done_r;
	assign rx_o   = rx_r;

endmodule : sfq_shifter

// file: rtl/sfq_sequencer.sv
// flash command sequencer: boot unprotect, write-enable preamble, command framing
// Function
// - boot: enable, poll latch, write zero status
// - enable and poll before program or erase
// - one fixed protocol and clock rate
// - fast read: 0x0b, address, dummy, data
// - program 0x02, sector 0x20, chip 0xc7
// - status read 0x05, write 0x01, enable 0x06
// - only one status byte per write
// - clock, data, primary select float in reset
// - secondary select stays driven in reset
// - controller programs flash when commanded
// - mode 0, single data line each way
module sfq_sequencer
(
	// clock and reset
	input  wire logic                 core_clk_i,
	input  wire logic                 nrst_i,
	// user request port
	input  wire logic                 req_valid_i,
	input  wire sfq_pkg::sfq_req_type req_i,
	output logic                      req_ready_o,
	output logic                      boot_done_o,
	// write data stream into a page program
	input  wire logic                 wr_valid_i,
	input  wire logic [7:0]           wr_data_i,
	input  wire logic                 wr_last_i,
	output logic                      wr_ready_o,
	// read data stream out of a fast read
	output logic                      rd_valid_o,
	output logic [7:0]                rd_data_o,
	input  wire logic                 rd_stop_i,
	// flash pins, enables low while driving
	output logic                      flash_serial_clock_pin_o,
	output logic                      flash_serial_clock_pin_oe_n_o,
	output logic                      flash_data_out_pin_o,
	output logic                      flash_data_out_pin_oe_n_o,
	output logic                      flash_primary_select_pin_n_o,
	output logic                      flash_primary_select_pin_oe_n_o,
	output logic                      flash_secondary_select_pin_n_o,
	input  wire logic                 flash_data_in_pin_i
);

	typedef enum logic [3:0]
	{
		ST_GAP     = 4'h0,
		ST_IDLE    = 4'h1,
		ST_WRITE_ENABLE_COMMAND    = 4'h2,
		ST_POLL    = 4'h3,
		ST_UNPROT  = 4'h4,
		ST_CMD     = 4'h5,
		ST_RDDATA  = 4'h6,
		ST_WRDATA  = 4'h7
	} sfq_state_type;

	logic rst_meta_r;
	logic rst_sync_r;
	logic miso_meta_r;
	logic miso_sync_r;

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
		begin
			miso_meta_r <= 1'b0;
			miso_sync_r <= 1'b0;
		end
		else
		begin
			miso_meta_r <= flash_data_in_pin_i;
			miso_sync_r <= miso_meta_r;
		end
	end

	// fixed rate divider, no probing of the attached part
	logic                  sh_start;
	sfq_pkg::sfq_byte_type sh_tx;
	logic                  sh_done;
	logic [7:0]            sh_rx;
	logic                  sh_sclk;
	logic                  sh_mosi;

	sfq_shifter u_shifter
	(
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_sync_r),
		.start_i    (sh_start),
		.tx_i       (sh_tx),
		.done_o     (sh_done),
		.rx_o       (sh_rx),
		.miso_i     (miso_sync_r),
		.sclk_o     (sh_sclk),
		.mosi_o     (sh_mosi)
	);

	sfq_state_type  st_r, st_nxt;
	sfq_state_type  after_gap_r, after_gap_nxt;
	logic [2:0]     idx_r, idx_nxt;
	logic           pend_r, pend_nxt;
	logic [7:0]     gap_r, gap_nxt;
	logic           cs_n_r, cs_n_nxt;
	logic           boot_r, boot_nxt;
	logic           boot_done_r, boot_done_nxt;
	sfq_pkg::sfq_req_type cur_r, cur_nxt;
	logic [7:0]     wbyte_r, wbyte_nxt;
	logic           wlast_r, wlast_nxt;
	logic           wr_ready_r, wr_ready_nxt;
	logic           rd_valid_r, rd_valid_nxt;
	logic [7:0]     rd_data_r, rd_data_nxt;
	logic           ready_r, ready_nxt;

	// opcode for a user op
	function automatic logic [7:0] op_code(input sfq_pkg::sfq_op_type op);
		case (op)
			sfq_pkg::SFQ_OP_READ:    op_code = sfq_pkg::OP_FAST_READ;
			sfq_pkg::SFQ_OP_PROGRAM: op_code = sfq_pkg::OP_PAGE_PROGRAM;
			sfq_pkg::SFQ_OP_SECTOR:  op_code = sfq_pkg::OP_SECTOR_ERASE;
			default:                 op_code = sfq_pkg::OP_CHIP_ERASE;
		endcase
	endfunction : op_code

	// number of header bytes minus one: opcode, address, dummy
	function automatic logic [2:0] hdr_last(input sfq_pkg::sfq_op_type op);
		case (op)
			sfq_pkg::SFQ_OP_READ:  hdr_last = 3'h4;
			sfq_pkg::SFQ_OP_CHIP:  hdr_last = 3'h0;
			default:               hdr_last = 3'h3;
		endcase
	endfunction : hdr_last

	always_comb
	begin
		st_nxt        = st_r;
		after_gap_nxt = after_gap_r;
		idx_nxt       = idx_r;
		pend_nxt      = pend_r;
		gap_nxt       = gap_r;
		cs_n_nxt      = cs_n_r;
		boot_nxt      = boot_r;
		boot_done_nxt = boot_done_r;
		cur_nxt       = cur_r;
		wbyte_nxt     = wbyte_r;
		wlast_nxt     = wlast_r;
		wr_ready_nxt  = 1'b0;
		rd_valid_nxt  = 1'b0;
		rd_data_nxt   = rd_data_r;
		ready_nxt     = 1'b0;
		sh_start      = 1'b0;
		sh_tx         = '{data: 8'h00, last: 1'b0};
		case (st_r)
			ST_GAP:
			begin
				// deselect time between commands
				cs_n_nxt = 1'b1;
				if (gap_r != 8'h00)
					gap_nxt = gap_r - 8'h01;
				else
				begin
					st_nxt  = after_gap_r;
					idx_nxt = 3'h0;
					pend_nxt = 1'b0;
					if (after_gap_r == ST_IDLE)
						ready_nxt = 1'b1;
					else
						cs_n_nxt = 1'b0;
				end
			end
			ST_IDLE:
			begin
				ready_nxt = 1'b1;
				if (req_valid_i && ready_r)
				begin
					cur_nxt   = req_i;
					ready_nxt = 1'b0;
					// reads skip the preamble; every modify gets a fresh one
					st_nxt   = (req_i.op == sfq_pkg::SFQ_OP_READ) ? ST_CMD : ST_WRITE_ENABLE_COMMAND;
					cs_n_nxt = 1'b0;
					idx_nxt  = 3'h0;
					pend_nxt = 1'b0;
				end
			end
			ST_WRITE_ENABLE_COMMAND:
			begin
				if (!pend_r)
				begin
					sh_start = 1'b1;
					sh_tx    = '{data: sfq_pkg::OP_WRITE_ENABLE, last: 1'b1};
					pend_nxt = 1'b1;
				end
				else if (sh_done)
				begin
					st_nxt        = ST_GAP;
					after_gap_nxt = ST_POLL;
					gap_nxt       = sfq_pkg::CS_HIGH_LAST;
					cs_n_nxt      = 1'b1;
				end
			end
			ST_POLL:
			begin
				if (!pend_r)
				begin
					sh_start = 1'b1;
					sh_tx = '{data: (idx_r == 3'h0) ? sfq_pkg::OP_STATUS_READ : 8'h00,
						last: idx_r == 3'h1};
					pend_nxt = 1'b1;
				end
				else if (sh_done)
				begin
					pend_nxt = 1'b0;
					idx_nxt  = idx_r + 3'h1;
					if (idx_r == 3'h1)
					begin
						st_nxt   = ST_GAP;
						gap_nxt  = sfq_pkg::CS_HIGH_LAST;
						cs_n_nxt = 1'b1;
						// repeat the poll until the latch reads set
						if (!sh_rx[sfq_pkg::WEL_BIT])
							after_gap_nxt = ST_POLL;
						else
							after_gap_nxt = boot_r ? ST_UNPROT : ST_CMD;
					end
				end
			end
			ST_UNPROT:
			begin
				if (!pend_r)
				begin
					sh_start = 1'b1;
					// one status byte only, never an expansion byte
					sh_tx = '{data: (idx_r == 3'h0) ? sfq_pkg::OP_STATUS_WRITE
						: sfq_pkg::STATUS_UNPROTECT, last: idx_r == 3'h1};
					pend_nxt = 1'b1;
				end
				else if (sh_done)
				begin
					pend_nxt = 1'b0;
					idx_nxt  = idx_r + 3'h1;
					if (idx_r == 3'h1)
					begin
						boot_nxt      = 1'b0;
						boot_done_nxt = 1'b1;
						st_nxt        = ST_GAP;
						after_gap_nxt = ST_IDLE;
						gap_nxt       = sfq_pkg::CS_HIGH_LAST;
						cs_n_nxt      = 1'b1;
					end
				end
			end
			ST_CMD:
			begin
				if (!pend_r)
				begin
					sh_start = 1'b1;
					case (idx_r)
						3'h0: sh_tx.data = op_code(cur_r.op);
						3'h1: sh_tx.data = cur_r.addr[23:16];
						3'h2: sh_tx.data = cur_r.addr[15:8];
						3'h3: sh_tx.data = cur_r.addr[7:0];
						default: sh_tx.data = 8'h00;
					endcase
					pend_nxt = 1'b1;
				end
				else if (sh_done)
				begin
					pend_nxt = 1'b0;
					idx_nxt  = idx_r + 3'h1;
					if (idx_r == hdr_last(cur_r.op))
					begin
						case (cur_r.op)
							sfq_pkg::SFQ_OP_READ:    st_nxt = ST_RDDATA;
							sfq_pkg::SFQ_OP_PROGRAM:
							begin
								st_nxt       = ST_WRDATA;
								wr_ready_nxt = 1'b1;
							end
							default:
							begin
								st_nxt        = ST_GAP;
								after_gap_nxt = ST_IDLE;
								gap_nxt       = sfq_pkg::CS_HIGH_LAST;
								cs_n_nxt      = 1'b1;
							end
						endcase
					end
				end
			end
			ST_RDDATA:
			begin
				// data streams while selected; stop is honoured at a byte boundary
				if (!pend_r)
				begin
					if (rd_stop_i)
					begin
						st_nxt        = ST_GAP;
						after_gap_nxt = ST_IDLE;
						gap_nxt       = sfq_pkg::CS_HIGH_LAST;
						cs_n_nxt      = 1'b1;
					end
					else
					begin
						sh_start = 1'b1;
						pend_nxt = 1'b1;
					end
				end
				else if (sh_done)
				begin
					pend_nxt     = 1'b0;
					rd_valid_nxt = 1'b1;
					rd_data_nxt  = sh_rx;
				end
			end
			ST_WRDATA:
			begin
				if (!pend_r)
				begin
					wr_ready_nxt = 1'b1;
					if (wr_valid_i && wr_ready_r)
					begin
						wr_ready_nxt = 1'b0;
						wbyte_nxt    = wr_data_i;
						wlast_nxt    = wr_last_i;
						pend_nxt     = 1'b1;
					end
				end
				else if (idx_r != 3'h7)
				begin
					sh_start = 1'b1;
					sh_tx    = '{data: wbyte_r, last: wlast_r};
					idx_nxt  = 3'h7;
				end
				else if (sh_done)
				begin
					pend_nxt = 1'b0;
					idx_nxt  = 3'h0;
					if (wlast_r)
					begin
						st_nxt        = ST_GAP;
						after_gap_nxt = ST_IDLE;
						gap_nxt       = sfq_pkg::CS_HIGH_LAST;
						cs_n_nxt      = 1'b1;
					end
					else
						wr_ready_nxt = 1'b1;
				end
			end
			default:
			begin
				st_nxt   = ST_GAP;
				cs_n_nxt = 1'b1;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
		begin
			// boot starts with the write-enable preamble
			st_r        <= ST_GAP;
			after_gap_r <= ST_WRITE_ENABLE_COMMAND;
			idx_r       <= 3'h0;
			pend_r      <= 1'b0;
			gap_r       <= sfq_pkg::CS_HIGH_LAST;
			cs_n_r      <= 1'b1;
			boot_r      <= 1'b1;
			boot_done_r <= 1'b0;
			cur_r       <= '0;
			wbyte_r     <= 8'h00;
			wlast_r     <= 1'b0;
			wr_ready_r  <= 1'b0;
			rd_valid_r  <= 1'b0;
			rd_data_r   <= 8'h00;
			ready_r     <= 1'b0;
		end
		else
		begin
			st_r        <= st_nxt;
			after_gap_r <= after_gap_nxt;
			idx_r       <= idx_nxt;
			pend_r      <= pend_nxt;
			gap_r       <= gap_nxt;
			cs_n_r      <= cs_n_nxt;
			boot_r      <= boot_nxt;
			boot_done_r <= boot_done_nxt;
			cur_r       <= cur_nxt;
			wbyte_r     <= wbyte_nxt;
			wlast_r     <= wlast_nxt;
			wr_ready_r  <= wr_ready_nxt;
			rd_valid_r  <= rd_valid_nxt;
			rd_data_r   <= rd_data_nxt;
			ready_r     <= ready_nxt;
		end
	end

	// pin stage: enables high (released) while the raw reset pin is low
	logic sclk_q_r, mosi_q_r, oe_n_r, cs2_n_r;

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			sclk_q_r <= 1'b0;
			mosi_q_r <= 1'b0;
			oe_n_r   <= 1'b1;
		end
		else
		begin
			sclk_q_r <= sh_sclk;
			mosi_q_r <= sh_mosi;
			oe_n_r   <= !rst_sync_r;
		end
	end

	// secondary select is never released and stays deselected; the reset
	// branch only keeps it from floating unknown before the first clock
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			cs2_n_r <= 1'b1;
		else
			cs2_n_r <= 1'b1;
	end

	assign flash_serial_clock_pin_o        = sclk_q_r;
	assign flash_serial_clock_pin_oe_n_o   = oe_n_r;
	assign flash_data_out_pin_o            = mosi_q_r;
	assign flash_data_out_pin_oe_n_o       = oe_n_r;
	assign flash_primary_select_pin_n_o    = cs_n_r;
	assign flash_primary_select_pin_oe_n_o = oe_n_r;
	assign flash_secondary_select_pin_n_o  = cs2_n_r;
	assign req_ready_o                     = ready_r;
	assign boot_done_o                     = boot_done_r;
	assign wr_ready_o                      = wr_ready_r;
	assign rd_valid_o                      = rd_valid_r;
	assign rd_data_o                       = rd_data_r;

endmodule : sfq_sequencer

// file: test/sfq_sequencer_monitor.sv
// checker: pin-level framing, timing and reset release of the flash sequencer
module sfq_sequencer_monitor
(
	// clock and reset
	input  wire logic core_clk_i,
	input  wire logic nrst_i,
	// flash pins
	input  wire logic flash_serial_clock_pin_o,
	input  wire logic flash_serial_clock_pin_oe_n_o,
	input  wire logic flash_data_out_pin_o,
	input  wire logic flash_data_out_pin_oe_n_o,
	input  wire logic flash_primary_select_pin_n_o,
	input  wire logic flash_primary_select_pin_oe_n_o,
	input  wire logic flash_secondary_select_pin_n_o
);
	timeunit 1ns;
	timeprecision 1ps;

	wire         sck = flash_serial_clock_pin_o;
	wire         cs  = flash_primary_select_pin_n_o;
	wire         mo  = flash_data_out_pin_o;
	logic [7:0]  hi_r;
	logic [7:0]  hi_nxt;
	logic [15:0] edge_r;
	logic [15:0] edge_nxt;
	logic        sck_q_r;

	// select-high run saturates; a full run before the first command is assumed
	always_comb
	begin
		hi_nxt   = cs ? ((hi_r == 8'hff) ? hi_r : hi_r + 8'h01) : 8'h00;
		edge_nxt = cs ? 16'h0000 : edge_r + {15'h0000, sck & ~sck_q_r};
	end

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			hi_r    <= 8'hff;
			edge_r  <= 16'h0000;
			sck_q_r <= 1'b0;
		end
		else
		begin
			hi_r    <= hi_nxt;
			edge_r  <= edge_nxt;
			sck_q_r <= sck;
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_high_phase;
		sck [*2] ##1 !sck;
	endsequence

	AST_RELEASED_IN_RESET: assert property (disable iff (1'b0) !nrst_i |->
		flash_serial_clock_pin_oe_n_o && flash_data_out_pin_oe_n_o && flash_primary_select_pin_oe_n_o)
		else $error("flash pins driven during reset");
	AST_OE_TOGETHER: assert property (disable iff (1'b0)
		flash_serial_clock_pin_oe_n_o == flash_data_out_pin_oe_n_o &&
		flash_data_out_pin_oe_n_o == flash_primary_select_pin_oe_n_o)
		else $error("flash pin enables differ");
	AST_SECONDARY_HELD: assert property (disable iff (1'b0) flash_secondary_select_pin_n_o)
		else $error("secondary select not held high");
	AST_DRIVE_AFTER_RESET: assert property ($rose(nrst_i) |-> ##[1:8] !flash_serial_clock_pin_oe_n_o)
		else $error("pins not driven after reset release");
	AST_CLK_IDLE_LOW: assert property (cs |-> !sck)
		else $error("serial clock high while deselected");
	AST_HALF_PERIOD: assert property ($rose(sck) |-> s_high_phase)
		else $error("serial clock high phase not two cycles");
	AST_MOSI_HOLD: assert property ($rose(sck) && !cs |=> $stable(mo))
		else $error("data out changed while clock high");
	AST_WHOLE_BYTES: assert property ($rose(cs) |-> edge_r[2:0] == 3'h0 && edge_r != 16'h0000)
		else $error("command not a whole number of bytes");
	AST_DESELECT_GAP: assert property ($fell(cs) |-> hi_r >= 8'h14)
		else $error("select high time too short");
endmodule : sfq_sequencer_monitor

bind sfq_sequencer sfq_sequencer_monitor mon
(
	.core_clk_i                      (core_clk_i),
	.nrst_i                          (nrst_i),
	.flash_serial_clock_pin_o        (flash_serial_clock_pin_o),
	.flash_serial_clock_pin_oe_n_o   (flash_serial_clock_pin_oe_n_o),
	.flash_data_out_pin_o            (flash_data_out_pin_o),
	.flash_data_out_pin_oe_n_o       (flash_data_out_pin_oe_n_o),
	.flash_primary_select_pin_n_o    (flash_primary_select_pin_n_o),
	.flash_primary_select_pin_oe_n_o (flash_primary_select_pin_oe_n_o),
	.flash_secondary_select_pin_n_o  (flash_secondary_select_pin_n_o)
);

// file: test/sfq_flash_model.sv
// partner: behavioural serial flash target, mode 0, logs every command
module sfq_flash_model
(
	// serial lines as seen on the board
	input  wire logic       sclk_i,
	input  wire logic       cs_n_i,
	input  wire logic       mosi_i,
	output logic            miso_o,
	// status polls before the latch shows
	input  wire logic [1:0] wel_lag_i
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0]  sr = 8'h00, sh = 8'h00, ob = 8'h00, op = 8'h00;
	logic [23:0] a = 24'h000000;
	int          bits = 0, nb = 0, left = 0, bad = 0;
	logic [7:0]  ops[$], data[$], srw[$];
	logic [23:0] addrs[$];
	int          lens[$];

	function automatic logic [7:0] rd_mem(input logic [23:0] ad);
		return ad[7:0] ^ ad[15:8] ^ 8'h3c;
	endfunction : rd_mem

	initial miso_o = 1'b0;

	always @(negedge cs_n_i)
	begin
		bits = 0;
		nb = 0;
	end

	always @(posedge sclk_i)
	if (!cs_n_i)
	begin
		sh = {sh[6:0], mosi_i};
		bits++;
		if (bits % 8 == 0)
		begin
			nb++;
			if (nb == 1 && sh == 8'h02) data.delete();
			if (nb == 1) op = sh;
			else if (nb <= 4 && op inside {8'h0b, 8'h02, 8'h20}) a = {a[15:0], sh};
			else if (op == 8'h02) data.push_back(sh);
			else if (op == 8'h01 && nb == 2) srw.push_back(sh);
		end
	end

	// next bit goes out after the falling edge
	always @(negedge sclk_i)
	if (!cs_n_i)
	begin
		if (bits % 8 == 0 && op == 8'h05 && nb >= 1) ob = sr;
		if (bits % 8 == 0 && op == 8'h0b && nb >= 5) ob = rd_mem(a + 24'(nb - 5));
		miso_o = ob[7];
		ob = {ob[6:0], 1'b0};
	end

	// a released data line must not keep looking valid
	always @(posedge cs_n_i)
	begin
		miso_o = ~miso_o;
		if (nb > 0)
		begin
			ops.push_back(op);
			lens.push_back(nb);
			addrs.push_back(a);
		end
		if (nb == 0)
			left = left;
		else if (op == 8'h06)
		begin
			left = wel_lag_i;
			sr[1] = (left == 0);
		end
		else if (op == 8'h05 && left > 0)
		begin
			left--;
			sr[1] = (left == 0);
		end
		else if (op inside {8'h02, 8'h20, 8'hc7, 8'h01})
		begin
			if (!sr[1])
				bad++;
			sr[1] = 1'b0;
		end
	end
endmodule : sfq_flash_model

// file: test/spi_flash_command_sequencer_test.sv
// testbench: boot unprotect, write-enable preamble, command layouts, reset release
module spi_flash_command_sequencer_test;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
$display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end

	logic                 core_clk_i = 1'b0, nrst_i = 1'b1, req_valid = 1'b0;
	logic                 wr_valid = 1'b0, wr_last = 1'b0, rd_stop = 1'b0;
	sfq_pkg::sfq_req_type req = '0;
	logic [7:0]           wr_data = 8'h00;
	logic [1:0]           wel_lag = 2'h0;
	logic                 ready, boot_done, wr_ready, rd_valid, miso, cs2_n;
	logic                 sck, sck_oe_n, mo, mo_oe_n, cs_n, cs_oe_n;
	logic [7:0]           rd_data;
	int                   num_errors = 0, total_checks = 0, cycles = 0, seed = 56;
	int                   pos = 0, rd_want = 0;
	logic [7:0]           wr_q[$], rd_q[$], sent[$];

	sfq_sequencer dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .req_valid_i(req_valid),
		.req_i(req), .req_ready_o(ready), .boot_done_o(boot_done), .wr_valid_i(wr_valid),
		.wr_data_i(wr_data), .wr_last_i(wr_last), .wr_ready_o(wr_ready),
		.rd_valid_o(rd_valid), .rd_data_o(rd_data), .rd_stop_i(rd_stop),
		.flash_serial_clock_pin_o(sck), .flash_serial_clock_pin_oe_n_o(sck_oe_n),
		.flash_data_out_pin_o(mo), .flash_data_out_pin_oe_n_o(mo_oe_n),
		.flash_primary_select_pin_n_o(cs_n), .flash_primary_select_pin_oe_n_o(cs_oe_n),
		.flash_secondary_select_pin_n_o(cs2_n), .flash_data_in_pin_i(miso));

	// released pins: clock pulled low, select pulled high
	sfq_flash_model flash (.sclk_i(sck_oe_n ? 1'b0 : sck), .cs_n_i(cs_oe_n ? 1'b1 : cs_n),
		.mosi_i(mo_oe_n ? 1'b1 : mo), .miso_o(miso), .wel_lag_i(wel_lag));

	initial forever #5 core_clk_i = ~core_clk_i;

	function automatic logic [7:0] exp_byte(input logic [23:0] ad);
		return ad[7:0] ^ ad[15:8] ^ 8'h3c;
	endfunction : exp_byte

	task end_sim;
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	// write stream, read capture and the hang limit
	always @(posedge core_clk_i)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			num_errors++;
			end_sim();
		end
		if (wr_valid && wr_ready === 1'b1)
			void'(wr_q.pop_front());
		if (rd_valid === 1'b1)
			rd_q.push_back(rd_data);
		wr_valid <= wr_q.size() != 0;
		wr_data <= (wr_q.size() != 0) ? wr_q[0] : 8'h00;
		wr_last <= wr_q.size() == 1;
		rd_stop <= rd_q.size() >= rd_want;
	end

	task wait_ready;
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 20000)
		begin
			@(posedge core_clk_i);
			n++;
		end
		`CHK("ready", 1'b1, ready)
	endtask : wait_ready

	task check_cmd(input string n, input logic [7:0] op, input int len);
		`CHK(n, op, (pos < flash.ops.size()) ? flash.ops[pos] : 8'hxx)
		`CHK(n, len, (pos < flash.lens.size()) ? flash.lens[pos] : -1)
		pos++;
	endtask : check_cmd

	task check_flow(input logic [7:0] op, input int len);
		check_cmd("enable", sfq_pkg::OP_WRITE_ENABLE, 1);
		repeat (int'(wel_lag) + 1) check_cmd("poll", sfq_pkg::OP_STATUS_READ, 2);
		check_cmd("modify", op, len);
	endtask : check_flow

	task do_op(input sfq_pkg::sfq_op_type op, input logic [23:0] a, input int n);
		logic [7:0] opc;
		wait_ready();
		wel_lag <= 2'($unsigned($random(seed)));
		rd_q.delete();
		rd_want = n;
		sent.delete();
		for (int i = 0; i < n && op == sfq_pkg::SFQ_OP_PROGRAM; i++)
			sent.push_back(8'($random(seed)));
		wr_q = sent;
		req_valid <= 1'b1;
		req <= '{op, a};
		@(posedge core_clk_i);
		req_valid <= 1'b0;
		// ready still reads high at the accepting edge; let it drop first
		@(posedge core_clk_i);
		wait_ready();
		@(posedge core_clk_i);
		if (op == sfq_pkg::SFQ_OP_READ)
		begin
			`CHK("read op", sfq_pkg::OP_FAST_READ, flash.ops[pos])
			`CHK("read len", 1'b1, flash.lens[pos] >= 5 + n)
			`CHK("read addr", a, flash.addrs[pos])
			pos++;
			for (int i = 0; i < n; i++)
				`CHK("read data", exp_byte(a + 24'(i)), rd_q[i])
			return;
		end
		opc = (op == sfq_pkg::SFQ_OP_PROGRAM) ? sfq_pkg::OP_PAGE_PROGRAM :
			(op == sfq_pkg::SFQ_OP_SECTOR) ? sfq_pkg::OP_SECTOR_ERASE : sfq_pkg::OP_CHIP_ERASE;
		check_flow(opc, (op == sfq_pkg::SFQ_OP_CHIP) ? 1 : 4 + sent.size());
		if (op != sfq_pkg::SFQ_OP_CHIP)
			`CHK("address", a, flash.addrs[pos - 1])
		for (int i = 0; i < sent.size(); i++)
			`CHK("program data", sent[i], flash.data[i])
		`CHK("latch before modify", 0, flash.bad)
	endtask : do_op

	task check_boot;
		wait_ready();
		check_flow(sfq_pkg::OP_STATUS_WRITE, 2);
		`CHK("status written", sfq_pkg::STATUS_UNPROTECT, flash.srw[flash.srw.size() - 1])
		`CHK("boot done", 1'b1, boot_done)
	endtask : check_boot

	initial
	begin
		// a real falling edge at time zero so the asynchronous resets take hold
		nrst_i <= 1'b0;
		repeat (10) @(posedge core_clk_i);
		`CHK("released", 3'h7, {sck_oe_n, mo_oe_n, cs_oe_n})
		nrst_i <= 1'b1;
		check_boot();
		// corner cases: every operation, address wrap and one-byte program
		do_op(sfq_pkg::SFQ_OP_READ, 24'hfffffe, 3);
		do_op(sfq_pkg::SFQ_OP_PROGRAM, 24'hffffff, 1);
		do_op(sfq_pkg::SFQ_OP_SECTOR, 24'h000000, 1);
		do_op(sfq_pkg::SFQ_OP_CHIP, 24'h123456, 1);
		do_op(sfq_pkg::SFQ_OP_PROGRAM, 24'h000100, 4);
		repeat (8)
			do_op(sfq_pkg::sfq_op_type'(2'($unsigned($random(seed)))), 24'($random(seed)),
				1 + int'(2'($unsigned($random(seed)))));
		// reset in the middle of a program preamble
		wait_ready();
		wr_q = '{8'h11, 8'h22, 8'h33};
		req_valid <= 1'b1;
		req <= '{sfq_pkg::SFQ_OP_PROGRAM, 24'h00aa00};
		@(posedge core_clk_i);
		req_valid <= 1'b0;
		repeat (150) @(posedge core_clk_i);
		nrst_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		`CHK("released", 3'h7, {sck_oe_n, mo_oe_n, cs_oe_n})
		`CHK("secondary", 1'b1, cs2_n)
		wr_q.delete();
		repeat (10) @(posedge core_clk_i);
		flash.ops.delete();
		flash.lens.delete();
		flash.addrs.delete();
		pos = 0;
		nrst_i <= 1'b1;
		check_boot();
		do_op(sfq_pkg::SFQ_OP_READ, 24'h00ff00, 2);
		end_sim();
	end
endmodule : spi_flash_command_sequencer_test
